// ---- logic/psf_pkg.sv ----
// Constants, types and register map of the packet sync and address filter.
// Assumes one device clock; all users qualify names with the package.
package psf_pkg;
  // Register offsets
  localparam logic [5:0] A_THR  = 6'h03;
  localparam logic [5:0] A_SHI  = 6'h04;
  localparam logic [5:0] A_SLO  = 6'h05;
  localparam logic [5:0] A_LEN  = 6'h06;
  localparam logic [5:0] A_CTL1 = 6'h07;
  localparam logic [5:0] A_CTL0 = 6'h08;
  localparam logic [5:0] A_ADDR = 6'h09;
  localparam logic [5:0] A_STAT = 6'h30;
  // Reset values and writable masks
  localparam logic [7:0] RST_THR  = 8'h07;
  localparam logic [7:0] RST_SHI  = 8'hD3;
  localparam logic [7:0] RST_SLO  = 8'h91;
  localparam logic [7:0] RST_LEN  = 8'hFF;
  localparam logic [7:0] RST_CTL1 = 8'h04;
  localparam logic [7:0] RST_CTL0 = 8'h45;
  localparam logic [7:0] RST_ADDR = 8'h00;
  localparam logic [7:0] MSK_CTL1 = 8'hEF;
  localparam logic [7:0] MSK_CTL0 = 8'h77;
  // Field positions
  localparam int PQT_LSB   = 5;
  localparam int PURGE_BIT = 3;
  localparam int TRAIL_BIT = 2;
  localparam int OVF_BIT   = 7;
  // Length modes and address filter settings
  localparam logic [1:0] LEN_FIXED = 2'h0;
  localparam logic [1:0] LEN_VAR   = 2'h1;
  localparam logic [1:0] LEN_INF   = 2'h2;
  localparam logic [1:0] AF_NONE   = 2'h0;
  localparam logic [1:0] AF_ZERO   = 2'h2;
  localparam logic [1:0] AF_BOTH   = 2'h3;
  localparam logic [7:0] BC_ZERO   = 8'h00;
  localparam logic [7:0] BC_ONES   = 8'hFF;
  // Quality estimator steps and FIFO shape
  localparam logic [7:0] PQE_UP    = 8'h01;
  localparam logic [7:0] PQE_DOWN  = 8'h08;
  localparam logic [6:0] THR_STEP  = 7'h04;
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 8;

  typedef struct packed {
    logic [15:0] sync;
    logic [7:0]  len;
    logic [2:0]  preamble_quality_limit;
    logic        purge;
    logic        trail;
    logic [1:0]  adrchk;
    logic [1:0]  lenmode;
    logic [7:0]  addr;
    logic [3:0]  thr;
  } psf_cfg_t;

  typedef enum logic [4:0] {
    ST_SEARCH = 5'h01,
    ST_LEN    = 5'h02,
    ST_BODY   = 5'h04,
    ST_STAT1  = 5'h08,
    ST_STAT2  = 5'h10
  } psf_state_t;
endpackage : psf_pkg

// ---- logic/psf_top.sv ----
// Receive packet framer: sync search, length, address filter, trailer, FIFO.
// Assumes link clock/data from pins, rssi/lqi/crc_ok from same-clock logic.
//
// Behaviour
// - Sync pattern upper byte comes from sync high register, reset D3.
// - Sync pattern lower byte comes from sync low register, reset 91.
// - Fixed length mode uses the length register, reset FF, as exact length.
// - Variable length mode treats the length register as the maximum.
// - Quality counter adds one for each bit differing from the previous.
// - Quality counter subtracts eight for each bit equal to the previous.
// - Sync detection allowed only when counter reaches four times threshold.
// - Threshold zero accepts a matching sync pattern unconditionally.
// - With purge bit set, a CRC failure empties the receive FIFO.
// - Trailer enable, set at reset, appends two status bytes.
// - Status bytes carry signal strength, link quality and CRC flag.
// - Filter 00 none, 01 address only, 10 address plus 00 broadcast.
// - Filter 11 also accepts 00 and FF as broadcast.
// - Threshold reached when FIFO byte count is at least four times (threshold plus one).
// - Address byte is compared with the programmed device address.
// - Variable length takes the length from the first byte after sync.
// - Length mode 00 fixed, 10 unbounded, 11 reserved.
`timescale 1ns/1ns

module psf_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic         flush,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data,
  output logic [$clog2(D):0] count
);
  localparam int PW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [PW:0]  wp;
  logic [PW:0]  rp;
  logic [PW:0]  next_wp;
  logic [PW:0]  next_rp;
  logic         wr;
  logic         rd;

  assign count     = wp - rp;
  assign in_ready  = (count != (PW+1)'(D));
  assign out_valid = (count != '0);
  assign out_data  = mem[rp[PW-1:0]];
  assign wr        = in_valid && in_ready;
  assign rd        = out_valid && out_ready;

  always_comb begin
    next_wp = wp;
    next_rp = rp;
    if (flush) begin
      next_wp = '0;
      next_rp = '0;
    end else begin
      if (wr) next_wp = wp + 1'b1;
      if (rd) next_rp = rp + 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wp <= '0;
      rp <= '0;
    end else if (ce) begin
      wp <= next_wp;
      rp <= next_rp;
    end
  end

  always_ff @(posedge clock) begin
    if (ce && wr && !flush) mem[wp[PW-1:0]] <= in_data;
  end
endmodule : psf_fifo

module psf_top (
  // Clock, reset, enable
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       ce,
  // Register port
  input  wire logic       reg_wr,
  input  wire logic [5:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic [7:0]      reg_rdata,
  // Link pins
  input  wire logic       link_clk,
  input  wire logic       link_data,
  // Receive quality from demodulator
  input  wire logic [7:0] rssi,
  input  wire logic [6:0] lqi,
  input  wire logic       crc_ok,
  // Receive byte stream
  output logic            out_valid,
  input  wire logic       out_ready,
  output logic [7:0]      out_data,
  // Events
  output logic            sync_seen,
  output logic            pkt_end,
  output logic            thr_hit
);
  // Address filter decision
  function automatic logic addr_ok(input logic [7:0] a, input psf_pkg::psf_cfg_t c);
    addr_ok = (a == c.addr)
           || (c.adrchk[1] && a == psf_pkg::BC_ZERO)
           || (c.adrchk == psf_pkg::AF_BOTH && a == psf_pkg::BC_ONES);
  endfunction : addr_ok

  logic [7:0] r_thr, r_shi, r_slo, r_len, r_c1, r_c0, r_adr;
  logic [7:0] next_thr, next_shi, next_slo, next_len, next_c1, next_c0, next_adr;
  logic [7:0] next_rdata;
  logic       ovf_clr;
  psf_pkg::psf_cfg_t cfg;

  assign cfg.sync    = {r_shi, r_slo};
  assign cfg.len     = r_len;
  assign cfg.preamble_quality_limit     = r_c1[psf_pkg::PQT_LSB +: 3];
  assign cfg.purge   = r_c1[psf_pkg::PURGE_BIT];
  assign cfg.trail   = r_c1[psf_pkg::TRAIL_BIT];
  assign cfg.adrchk  = r_c1[1:0];
  assign cfg.lenmode = r_c0[1:0];
  assign cfg.addr    = r_adr;
  assign cfg.thr     = r_thr[3:0];

  logic       ck1, ck2, ck3, dt1, dt2, prev;
  logic [7:0] pqe, next_pqe;
  logic [15:0] shr;
  logic       tick, match, gate;
  psf_pkg::psf_state_t st, next_st;
  logic [2:0] bcnt, next_bcnt;
  logic [7:0] bsr, next_bsr, rem, next_rem, pd, next_pd, nb;
  logic       first, next_first, pv, next_pv, ovf, next_ovf;
  logic       next_sync_seen, next_pkt_end, bdone, flush, fin, load;
  logic       f_rdy, f_ov, f_take, next_ov;
  logic [7:0] f_d, next_od;
  logic [3:0] f_cnt;
  logic [6:0] thr_lvl;

  // Register file
  always_comb begin
    next_thr = r_thr;
    next_shi = r_shi;
    next_slo = r_slo;
    next_len = r_len;
    next_c1  = r_c1;
    next_c0  = r_c0;
    next_adr = r_adr;
    ovf_clr  = 1'b0;
    if (reg_wr) begin
      unique case (reg_addr)
        psf_pkg::A_THR:  next_thr = reg_wdata;
        psf_pkg::A_SHI:  next_shi = reg_wdata;
        psf_pkg::A_SLO:  next_slo = reg_wdata;
        psf_pkg::A_LEN:  next_len = reg_wdata;
        psf_pkg::A_CTL1: next_c1  = reg_wdata & psf_pkg::MSK_CTL1;
        psf_pkg::A_CTL0: next_c0  = reg_wdata & psf_pkg::MSK_CTL0;
        psf_pkg::A_ADDR: next_adr = reg_wdata;
        psf_pkg::A_STAT: ovf_clr  = reg_wdata[psf_pkg::OVF_BIT];
        default:         next_thr = r_thr;
      endcase
    end
    unique case (reg_addr)
      psf_pkg::A_THR:  next_rdata = r_thr;
      psf_pkg::A_SHI:  next_rdata = r_shi;
      psf_pkg::A_SLO:  next_rdata = r_slo;
      psf_pkg::A_LEN:  next_rdata = r_len;
      psf_pkg::A_CTL1: next_rdata = r_c1;
      psf_pkg::A_CTL0: next_rdata = r_c0;
      psf_pkg::A_ADDR: next_rdata = r_adr;
      psf_pkg::A_STAT: next_rdata = {ovf, st != psf_pkg::ST_SEARCH, pv, 1'b0, f_cnt};
      default:         next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      r_thr     <= psf_pkg::RST_THR;
      r_shi     <= psf_pkg::RST_SHI;
      r_slo     <= psf_pkg::RST_SLO;
      r_len     <= psf_pkg::RST_LEN;
      r_c1      <= psf_pkg::RST_CTL1;
      r_c0      <= psf_pkg::RST_CTL0;
      r_adr     <= psf_pkg::RST_ADDR;
      reg_rdata <= 8'h00;
    end else if (ce) begin
      r_thr     <= next_thr;
      r_shi     <= next_shi;
      r_slo     <= next_slo;
      r_len     <= next_len;
      r_c1      <= next_c1;
      r_c0      <= next_c0;
      r_adr     <= next_adr;
      reg_rdata <= next_rdata;
    end
  end

  // Link sampling and quality estimator
  assign tick  = ck2 && !ck3;
  assign match = ({shr[14:0], dt2} == cfg.sync);
  assign gate  = (cfg.preamble_quality_limit == 3'h0) || (pqe >= {3'h0, cfg.preamble_quality_limit, 2'h0});

  always_comb begin
    next_pqe = pqe;
    if (tick) begin
      if (dt2 != prev) next_pqe = (pqe == 8'hFF) ? pqe : pqe + psf_pkg::PQE_UP;
      else next_pqe = (pqe < psf_pkg::PQE_DOWN) ? 8'h00 : pqe - psf_pkg::PQE_DOWN;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      {ck1, ck2, ck3, dt1, dt2, prev} <= 6'h00;
      pqe <= 8'h00;
      shr <= 16'h0000;
    end else if (ce) begin
      ck1 <= link_clk;
      ck2 <= ck1;
      ck3 <= ck2;
      dt1 <= link_data;
      dt2 <= dt1;
      pqe <= next_pqe;
      if (tick) begin
        prev <= dt2;
        shr  <= {shr[14:0], dt2};
      end
    end
  end

  // Packet engine
  assign nb    = {bsr[6:0], dt2};
  assign bdone = tick && (bcnt == 3'h7);

  always_comb begin
    next_st        = st;
    next_bcnt      = bcnt;
    next_bsr       = bsr;
    next_rem       = rem;
    next_first     = first;
    next_pv        = pv;
    next_pd        = pd;
    next_ovf       = ovf;
    next_sync_seen = 1'b0;
    next_pkt_end   = 1'b0;
    flush          = 1'b0;
    fin            = 1'b0;
    load           = 1'b0;
    if (tick) begin
      next_bsr  = nb;
      next_bcnt = bcnt + 3'h1;
    end
    if (pv && f_rdy) next_pv = 1'b0;
    unique case (st)
      psf_pkg::ST_SEARCH: begin
        if (tick && match && gate) begin
          next_bcnt      = 3'h0;
          next_sync_seen = 1'b1;
          next_first     = 1'b1;
          next_rem       = cfg.len;
          if (cfg.lenmode == psf_pkg::LEN_VAR) next_st = psf_pkg::ST_LEN;
          else next_st = psf_pkg::ST_BODY;
        end
      end
      psf_pkg::ST_LEN: begin
        if (bdone) begin
          if (nb == 8'h00 || nb > cfg.len) next_st = psf_pkg::ST_SEARCH;
          else begin
            next_pv  = 1'b1;
            next_pd  = nb;
            next_rem = nb;
            load     = 1'b1;
            next_st  = psf_pkg::ST_BODY;
          end
        end
      end
      psf_pkg::ST_BODY: begin
        if (bdone) begin
          next_first = 1'b0;
          if (first && cfg.adrchk != psf_pkg::AF_NONE && !addr_ok(nb, cfg)) begin
            flush   = 1'b1;
            next_st = psf_pkg::ST_SEARCH;
          end else begin
            next_pv  = 1'b1;
            next_pd  = nb;
            next_rem = rem - 8'h01;
            load     = 1'b1;
            if (cfg.lenmode != psf_pkg::LEN_INF && rem == 8'h01) begin
              if (cfg.trail) next_st = psf_pkg::ST_STAT1;
              else fin = 1'b1;
            end
          end
        end
      end
      psf_pkg::ST_STAT1: begin
        if (!pv) begin
          next_pv = 1'b1;
          next_pd = rssi;
          next_st = psf_pkg::ST_STAT2;
        end
      end
      psf_pkg::ST_STAT2: begin
        if (!pv) begin
          next_pv = 1'b1;
          next_pd = {crc_ok, lqi};
          fin     = 1'b1;
        end
      end
      default: next_st = psf_pkg::ST_SEARCH;
    endcase
    if (ovf_clr) next_ovf = 1'b0;
    if (pv && !f_rdy && load) begin
      next_ovf = 1'b1;
      next_pd  = pd;
    end
    if (fin) begin
      next_st      = psf_pkg::ST_SEARCH;
      next_pkt_end = 1'b1;
      if (cfg.purge && !crc_ok) flush = 1'b1;
    end
    if (flush) next_pv = 1'b0;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st        <= psf_pkg::ST_SEARCH;
      bcnt      <= 3'h0;
      bsr       <= 8'h00;
      rem       <= 8'h00;
      first     <= 1'b0;
      pv        <= 1'b0;
      pd        <= 8'h00;
      ovf       <= 1'b0;
      sync_seen <= 1'b0;
      pkt_end   <= 1'b0;
    end else if (ce) begin
      st        <= next_st;
      bcnt      <= next_bcnt;
      bsr       <= next_bsr;
      rem       <= next_rem;
      first     <= next_first;
      pv        <= next_pv;
      pd        <= next_pd;
      ovf       <= next_ovf;
      sync_seen <= next_sync_seen;
      pkt_end   <= next_pkt_end;
    end
  end

  // Receive FIFO and registered output stage
  psf_fifo #(.W(psf_pkg::FIFO_W), .D(psf_pkg::FIFO_D)) u_fifo (
    .clock     (clock),
    .rst       (rst),
    .ce        (ce),
    .flush     (flush),
    .in_valid  (pv),
    .in_ready  (f_rdy),
    .in_data   (pd),
    .out_valid (f_ov),
    .out_ready (f_take),
    .out_data  (f_d),
    .count     (f_cnt)
  );

  assign f_take  = !out_valid || out_ready;
  assign thr_lvl = 7'((7'(cfg.thr) + 7'h01) * psf_pkg::THR_STEP);

  always_comb begin
    next_ov = out_valid;
    next_od = out_data;
    if (flush) next_ov = 1'b0;
    else if (f_take) begin
      next_ov = f_ov;
      if (f_ov) next_od = f_d;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_data  <= 8'h00;
      thr_hit   <= 1'b0;
    end else if (ce) begin
      out_valid <= next_ov;
      out_data  <= next_od;
      thr_hit   <= ({3'h0, f_cnt} >= thr_lvl);
    end
  end

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_SYNC_ACCEPT: assert property (
    (ce && st == psf_pkg::ST_SEARCH && tick && match && gate) |=> sync_seen && st != psf_pkg::ST_SEARCH)
    else $error("sync match not accepted");
  AST_PQT_GATE: assert property (
    (ce && st == psf_pkg::ST_SEARCH && tick && cfg.preamble_quality_limit != 3'h0 && pqe < {3'h0, cfg.preamble_quality_limit, 2'h0})
    |=> st == psf_pkg::ST_SEARCH && !sync_seen)
    else $error("sync accepted below quality threshold");
  AST_PQT_ZERO: assert property (
    (ce && st == psf_pkg::ST_SEARCH && tick && match && cfg.preamble_quality_limit == 3'h0) |=> sync_seen)
    else $error("zero threshold did not accept sync");
  AST_PQE_UP: assert property (
    (ce && tick && dt2 != prev && pqe != 8'hFF) |=> pqe == $past(pqe) + 8'h01)
    else $error("quality counter did not add one");
  AST_PQE_DOWN: assert property (
    (ce && tick && dt2 == prev && pqe >= 8'h08) |=> pqe == $past(pqe) - 8'h08)
    else $error("quality counter did not subtract eight");
  AST_FIXED_LEN: assert property (
    (ce && st == psf_pkg::ST_SEARCH && tick && match && gate && cfg.lenmode == psf_pkg::LEN_FIXED)
    |=> st == psf_pkg::ST_BODY && rem == $past(r_len))
    else $error("fixed length not loaded");
  AST_VAR_MAX: assert property (
    (ce && st == psf_pkg::ST_LEN && bdone && nb > cfg.len) |=> st == psf_pkg::ST_SEARCH && !pkt_end)
    else $error("oversize length accepted");
  AST_VAR_LEN: assert property (
    (ce && st == psf_pkg::ST_LEN && bdone && nb != 8'h00 && nb <= cfg.len)
    |=> rem == $past(nb) && pd == $past(nb))
    else $error("length byte not taken");
  AST_PURGE: assert property (
    (ce && fin && cfg.purge && !crc_ok) |=> f_cnt == 4'h0 && !out_valid && !pv)
    else $error("failed packet not purged");
  AST_TRAILER: assert property (
    (ce && st == psf_pkg::ST_BODY && fin) |-> !cfg.trail)
    else $error("trailer skipped");
  AST_RSSI_BYTE: assert property (
    (ce && st == psf_pkg::ST_STAT1 && !pv) |=> pv && pd == $past(rssi))
    else $error("signal strength byte wrong");
  AST_BCAST_ONES: assert property (
    (ce && st == psf_pkg::ST_BODY && bdone && first && cfg.adrchk == psf_pkg::AF_BOTH && nb == 8'hFF)
    |=> pv && pd == 8'hFF)
    else $error("broadcast FF rejected");
  AST_UNBOUNDED: assert property (
    (ce && st == psf_pkg::ST_BODY && cfg.lenmode == psf_pkg::LEN_INF) |-> !fin)
    else $error("unbounded packet ended");
  AST_THR: assert property (
    ce |=> thr_hit == (($past(cfg.thr) == 4'h0 && $past(f_cnt) >= 4'h4)
                       || ($past(cfg.thr) == 4'h1 && $past(f_cnt) >= 4'h8)))
    else $error("threshold flag wrong");
  AST_CTL1_RSV: assert property (
    (ce && reg_addr == psf_pkg::A_CTL1) |=> reg_rdata[4] == 1'b0)
    else $error("unused control bit reads one");

  COV_SYNC:  cover property (ce && sync_seen);
  COV_END:   cover property (ce && pkt_end && out_valid);
  COV_PURGE: cover property (ce && fin && flush);
  COV_OVF:   cover property (ce && ovf);
endmodule : psf_top

// ---- tb/psf_link_tx.sv ----
// Link transmitter model: preamble, sync word, bytes MSB first.
// Assumes the caller waits for send to return before the next frame.
`timescale 1ns/1ns

module psf_link_tx (
  // Link pins
  output logic link_clk,
  output logic link_data
);
  initial begin
    link_clk  = 1'b0;
    link_data = 1'b0;
  end

  // One 125 ns bit, data set in low phase
  task automatic bit_out(input logic v);
    link_data = v;
    #31;
    link_clk = 1'b1;
    #63;
    link_clk = 1'b0;
    #31;
  endtask : bit_out

  // Preamble, sync word, then n bytes from the top of b
  task automatic send(input logic [15:0] sw, input int np,
                      input logic [127:0] b, input int n);
    for (int i = 0; i < np; i++) bit_out(i[0]);
    for (int i = 15; i >= 0; i--) bit_out(sw[i]);
    for (int i = 0; i < n * 8; i++) bit_out(b[127-i]);
    // Clock stops, released data line inverts
    link_data = ~link_data;
  endtask : send
endmodule : psf_link_tx

// ---- tb/tb_psf_top.sv ----
// Self-checking bench of the receive packet framer.
// Assumes psf_pkg, psf_top and psf_link_tx are compiled first.
`timescale 1ns/1ns

module tb_psf_top;
  typedef struct packed {
    logic [5:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } psf_row_t;

  logic         clock     = 1'b0;
  logic         rst       = 1'b1;
  logic         ce        = 1'b1;
  logic         reg_wr    = 1'b0;
  logic [5:0]   reg_addr  = 6'h00;
  logic [7:0]   reg_wdata = 8'h00;
  logic [7:0]   rssi      = 8'hC4;
  logic [6:0]   lqi       = 7'h2B;
  logic         crc_ok    = 1'b1;
  logic         out_ready = 1'b1;
  logic [7:0]   reg_rdata;
  logic [7:0]   out_data;
  logic         out_valid;
  logic         sync_seen;
  logic         pkt_end;
  logic         thr_hit;
  logic         link_clk;
  logic         link_data;
  logic [15:0]  sw = 16'hD391;
  logic [127:0] b;
  logic         ok;
  int           errors = 0;
  int           tests_run = 0;
  int           n_sync = 0;
  int           n_end = 0;
  int           n0;
  int           e0;
  logic [7:0]   rxq[$];
  logic [7:0]   expq[$];
  logic [7:0]   adr[4] = '{8'h5A, 8'h00, 8'hFF, 8'h77};
  psf_row_t     rows[6] = '{'{6'h04, 8'hA5, 8'hA5}, '{6'h05, 8'h3C, 8'h3C},
                            '{6'h06, 8'h20, 8'h20}, '{6'h07, 8'hFF, 8'hEF},
                            '{6'h03, 8'h01, 8'h01}, '{6'h0A, 8'h55, 8'h00}};

  always #5 clock = ~clock;

  psf_top dut (
    .clock(clock), .rst(rst), .ce(ce), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .link_clk(link_clk),
    .link_data(link_data), .rssi(rssi), .lqi(lqi), .crc_ok(crc_ok),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
    .sync_seen(sync_seen), .pkt_end(pkt_end), .thr_hit(thr_hit)
  );

  psf_link_tx link (.link_clk(link_clk), .link_data(link_data));

  // Capture stream bytes and event pulses
  always @(posedge clock) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) rxq.push_back(out_data);
    if (sync_seen === 1'b1) n_sync++;
    if (pkt_end === 1'b1) n_end++;
  end

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp8

  task automatic cmp1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp1

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    @(posedge clock);
    #1 cmp8(reg_rdata, e);
  endtask : rd

  // Expected bytes of an accepted packet plus trailer
  task automatic exp_pkt(input logic [127:0] v, input int n);
    for (int i = 0; i < n; i++) expq.push_back(v[127-8*i -: 8]);
    expq.push_back(rssi);
    expq.push_back({crc_ok, lqi});
  endtask : exp_pkt

  task automatic drain();
    cmp8(8'(rxq.size()), 8'(expq.size()));
    while (rxq.size() > 0 && expq.size() > 0) begin
      cmp8(rxq.pop_front(), expq.pop_front());
    end
    rxq.delete();
    expq.delete();
  endtask : drain

  // Send with consumer stalled, then release and compare
  task automatic pkt(input int np, input logic [127:0] v, input int n, input logic th);
    @(posedge clock);
    out_ready <= 1'b0;
    link.send(sw, np, v, n);
    repeat (40) @(posedge clock);
    cmp1(thr_hit, th);
    out_ready <= 1'b1;
    repeat (20) @(posedge clock);
    #1 drain();
  endtask : pkt

  task automatic tally_and_finish();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (60000) @(posedge clock);
    errors++;
    tally_and_finish();
  end

  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    // Mid-run reset restores defaults
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rd(6'h04, 8'hD3);
    rd(6'h05, 8'h91);
    rd(6'h06, 8'hFF);
    rd(6'h07, 8'h04);
    // Clock enable low freezes a write
    @(posedge clock);
    ce <= 1'b0;
    wr(6'h09, 8'h33);
    @(posedge clock);
    ce <= 1'b1;
    rd(6'h09, 8'h00);
    // Default variable packet with trailer
    n0 = n_sync;
    e0 = n_end;
    b = {8'h03, 8'h11, 8'h22, 8'h33, 96'h0};
    exp_pkt(b, 4);
    pkt(0, b, 4, 1'b0);
    cmp8(8'(n_sync - n0), 8'h01);
    cmp8(8'(n_end - e0), 8'h01);
    // Address filter, every mode and address kind
    wr(6'h09, 8'h5A);
    for (int m = 0; m < 4; m++) begin
      wr(6'h07, 8'h04 | 8'(m));
      for (int k = 0; k < 4; k++) begin
        ok = (m == 0) || (adr[k] == 8'h5A) || (m >= 2 && adr[k] == 8'h00)
             || (m == 3 && adr[k] == 8'hFF);
        b = {8'h02, adr[k], 8'h66, 104'h0};
        if (ok) exp_pkt(b, 3);
        pkt(0, b, 3, 1'b0);
      end
    end
    // Fixed length mode
    wr(6'h07, 8'h04);
    wr(6'h08, 8'h44);
    wr(6'h06, 8'h03);
    b = {8'h11, 8'h22, 8'h33, 104'h0};
    exp_pkt(b, 3);
    pkt(0, b, 3, 1'b0);
    // Variable length above and at the limit
    wr(6'h08, 8'h45);
    wr(6'h06, 8'h02);
    b = {8'h03, 8'h11, 8'h22, 8'h33, 96'h0};
    pkt(0, b, 4, 1'b0);
    b = {8'h02, 8'h11, 8'h22, 104'h0};
    exp_pkt(b, 3);
    pkt(0, b, 3, 1'b0);
    // Quality gate, without and with preamble
    sw = 16'h5556;
    wr(6'h04, 8'h55);
    wr(6'h05, 8'h56);
    wr(6'h07, 8'hE4);
    n0 = n_sync;
    b = {8'h01, 8'h77, 112'h0};
    pkt(0, b, 2, 1'b0);
    exp_pkt(b, 2);
    pkt(40, b, 2, 1'b0);
    cmp8(8'(n_sync - n0), 8'h01);
    wr(6'h07, 8'h0C);
    crc_ok <= 1'b0;
    b = {8'h02, 8'h11, 8'h22, 104'h0};
    pkt(0, b, 3, 1'b0);
    wr(6'h07, 8'h04);
    exp_pkt(b, 3);
    pkt(0, b, 3, 1'b0);
    // Threshold of four bytes at the boundary
    @(posedge clock);
    crc_ok <= 1'b1;
    wr(6'h03, 8'h00);
    exp_pkt(b, 3);
    pkt(0, b, 3, 1'b1);
    b = {8'h01, 8'h77, 112'h0};
    exp_pkt(b, 2);
    pkt(0, b, 2, 1'b0);
    // Unbounded length keeps bytes, never ends
    wr(6'h08, 8'h46);
    e0 = n_end;
    expq.push_back(8'h01);
    expq.push_back(8'h77);
    pkt(0, b, 2, 1'b0);
    cmp8(8'(n_end - e0), 8'h00);
    tally_and_finish();
  end
endmodule : tb_psf_top
